//--- logic/bfie_bit_unit.sv
/*
 * Single-bit replace and extract on one byte.
 * Assumes a three-bit bit index; purely combinational.
 */
`timescale 1ns/1ps
module bfie_bit_unit (
	// Operand
	input wire logic [7:0] value,
	input wire logic [2:0] bit_sel,
	input wire logic bit_in,
	// Results
	output logic [7:0] replaced,
	output logic bit_out
);

	always_comb begin
		replaced = value;
		replaced[bit_sel] = bit_in;
		bit_out = value[bit_sel];
	end

endmodule

//--- logic/bfie_exec.sv
/*
 * Bit and flag instruction executer with its AHB-Lite register slave.
 * Holds eight working registers, eight I/O registers and the flag register,
 * and runs one command at a time written to the command register.
 * Assumes a single AHB-Lite master, word transfers only, and hclk at 200 MHz.
 */
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - io_bit_assert sets chosen I/O bit, keeps flags, takes two cycles.
// - io_bit_negate clears chosen I/O bit, keeps flags, takes two cycles.
// - Left logical shift: bits up, zero into bit 0, Z C N V, one cycle.
// - Right logical shift: bits down, zero into bit 7, Z C N V, one cycle.
// - Left rotate: carry into bit 0, bit 7 into carry, Z C N V, one cycle.
// - Right rotate: carry into bit 7, bit 0 into carry, Z C N V, one cycle.
// - Arithmetic right shift keeps bit 7, moves others down, Z C N V, one cycle.
// - flag_from_reg_bit copies a register bit into copy flag only, one cycle.
// - reg_bit_from_flag writes copy flag into a register bit, flags kept, one cycle.
// - Overrun flag raised or dropped alone by its two commands, one cycle.
// - Nibble carry flag raised or dropped alone by its two commands, one cycle.
// - Sign flag raised or dropped alone by its two commands, one cycle.
module bfie_exec #(
	parameter int NUM_REGS = bfie_pkg::BFIE_NUM_REGS
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Core view
	output logic [7:0] flag_register,
	output logic busy
);
	import bfie_pkg::*;

	localparam int IDX_W = $clog2(NUM_REGS);

	// Word index of an address inside a bank, or all ones when outside it
	function automatic logic [IDX_W:0] bank_index(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] off;
		off = addr - base;
		if (addr >= base && off[1:0] == 2'b00 && off[7:2] < 6'(NUM_REGS)) begin
			bank_index = {1'b0, off[IDX_W+1:2]};
		end else begin
			bank_index = '1;
		end
	endfunction

	// Register state
	logic [7:0] work_reg [NUM_REGS];
	logic [7:0] io_reg [NUM_REGS];
	bfie_state_e state;
	logic cmd_dropped;
	logic [3:0] last_op;

	// Bus phase capture
	logic dp_write;
	logic [7:0] dp_addr;

	// Command fields
	logic [3:0] cmd_op;
	logic [IDX_W-1:0] cmd_reg;
	logic [2:0] cmd_bit;
	logic cmd_write;
	logic cmd_go;

	// Pending I/O write
	logic [IDX_W-1:0] io_idx;
	logic [2:0] io_bit;
	logic io_level;

	// Datapath wires
	logic [7:0] sh_result;
	logic sh_carry;
	logic sh_zero;
	logic sh_neg;
	logic sh_ovf;
	logic [7:0] wb_replaced;
	logic wb_bit;
	logic [7:0] io_replaced;
	logic [IDX_W:0] wr_widx;
	logic [IDX_W:0] wr_iidx;
	logic [IDX_W:0] rd_widx;
	logic [IDX_W:0] rd_iidx;
	logic is_shift;
	logic status_write;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign busy = (state == BFIE_IO_WRITE);

	// Address phase is taken on every ready edge; data phase follows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else if (hready) begin
			dp_write <= hsel && htrans[1] && hwrite;
			dp_addr <= haddr[7:0];
		end
	end

	assign wr_widx = bank_index(dp_addr, BFIE_WREG_BASE);
	assign wr_iidx = bank_index(dp_addr, BFIE_IOREG_BASE);
	assign rd_widx = bank_index(haddr[7:0], BFIE_WREG_BASE);
	assign rd_iidx = bank_index(haddr[7:0], BFIE_IOREG_BASE);

	assign cmd_write = dp_write && (dp_addr == BFIE_CMD_ADDR);
	assign status_write = dp_write && (dp_addr == BFIE_STATUS_ADDR);
	assign cmd_op = hwdata[BFIE_CMD_OP_LSB +: 4];
	assign cmd_reg = hwdata[BFIE_CMD_REG_LSB +: IDX_W];
	assign cmd_bit = hwdata[BFIE_CMD_BIT_LSB +: 3];
	// A command arriving while an I/O write is pending is dropped
	assign cmd_go = cmd_write && (state == BFIE_IDLE);
	assign is_shift = (cmd_op >= BFIE_OP_LEFT_LOGICAL_SHIFT)
		&& (cmd_op <= BFIE_OP_RIGHT_ARITH_SHIFT);

	bfie_shift_unit u_shift (
		.op(cmd_op),
		.operand(work_reg[cmd_reg]),
		.carry_in(flag_register[BFIE_F_CARRY]),
		.result(sh_result),
		.carry_out(sh_carry),
		.zero_out(sh_zero),
		.neg_out(sh_neg),
		.ovf_out(sh_ovf)
	);

	bfie_bit_unit u_wbit (
		.value(work_reg[cmd_reg]),
		.bit_sel(cmd_bit),
		.bit_in(flag_register[BFIE_F_COPY]),
		.replaced(wb_replaced),
		.bit_out(wb_bit)
	);

	bfie_bit_unit u_iobit (
		.value(io_reg[io_idx]),
		.bit_sel(io_bit),
		.bit_in(io_level),
		.replaced(io_replaced),
		.bit_out()
	);

	// Sequencer: I/O bit commands spend a second cycle on the write-back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= BFIE_IDLE;
		end else begin
			case (state)
				BFIE_IDLE: begin
					if (cmd_go && (cmd_op == BFIE_OP_IO_BIT_ASSERT
						|| cmd_op == BFIE_OP_IO_BIT_NEGATE)) begin
						state <= BFIE_IO_WRITE;
					end
				end
				BFIE_IO_WRITE: begin
					state <= BFIE_IDLE;
				end
				default: begin
					state <= BFIE_IDLE;
				end
			endcase
		end
	end

	// Latch the target of a pending I/O bit write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_idx <= '0;
			io_bit <= 3'd0;
			io_level <= 1'b0;
		end else if (cmd_go) begin
			io_idx <= cmd_reg;
			io_bit <= cmd_bit;
			io_level <= (cmd_op == BFIE_OP_IO_BIT_ASSERT);
		end
	end

	// Working registers: bus writes, shift results and bit loads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				work_reg[i] <= BFIE_REG_RESET;
			end
		end else if (cmd_go && is_shift) begin
			work_reg[cmd_reg] <= sh_result;
		end else if (cmd_go && cmd_op == BFIE_OP_REG_BIT_FROM_FLAG) begin
			work_reg[cmd_reg] <= wb_replaced;
		end else if (dp_write && !wr_widx[IDX_W]) begin
			work_reg[wr_widx[IDX_W-1:0]] <= hwdata[7:0];
		end
	end

	// I/O registers; the pending bit write wins over a bus write landing with it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				io_reg[i] <= BFIE_REG_RESET;
			end
		end else if (state == BFIE_IO_WRITE) begin
			io_reg[io_idx] <= io_replaced;
		end else if (dp_write && !wr_iidx[IDX_W]) begin
			io_reg[wr_iidx[IDX_W-1:0]] <= hwdata[7:0];
		end
	end

	// Flag register: each command touches only its own flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_register <= BFIE_FLAGS_RESET;
		end else if (cmd_go) begin
			case (cmd_op)
				BFIE_OP_LEFT_LOGICAL_SHIFT, BFIE_OP_RIGHT_LOGICAL_SHIFT,
				BFIE_OP_LEFT_CARRY_ROTATE, BFIE_OP_RIGHT_CARRY_ROTATE,
				BFIE_OP_RIGHT_ARITH_SHIFT: begin
					flag_register[BFIE_F_CARRY] <= sh_carry;
					flag_register[BFIE_F_ZERO] <= sh_zero;
					flag_register[BFIE_F_NEG] <= sh_neg;
					flag_register[BFIE_F_OVF] <= sh_ovf;
				end
				BFIE_OP_FLAG_FROM_REG_BIT: begin
					flag_register[BFIE_F_COPY] <= wb_bit;
				end
				BFIE_OP_OVERRUN_RAISE: begin
					flag_register[BFIE_F_OVF] <= 1'b1;
				end
				BFIE_OP_OVERRUN_DROP: begin
					flag_register[BFIE_F_OVF] <= 1'b0;
				end
				BFIE_OP_NIBBLE_RAISE: begin
					flag_register[BFIE_F_HALF] <= 1'b1;
				end
				BFIE_OP_NIBBLE_DROP: begin
					flag_register[BFIE_F_HALF] <= 1'b0;
				end
				BFIE_OP_SIGN_RAISE: begin
					flag_register[BFIE_F_SIGN] <= 1'b1;
				end
				BFIE_OP_SIGN_DROP: begin
					flag_register[BFIE_F_SIGN] <= 1'b0;
				end
				default: begin
					flag_register <= flag_register;
				end
			endcase
		end else if (dp_write && dp_addr == BFIE_FLAGS_ADDR) begin
			flag_register <= hwdata[7:0];
		end
	end

	// Dropped-command flag: a new drop wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_dropped <= 1'b0;
		end else if (cmd_write && state != BFIE_IDLE) begin
			cmd_dropped <= 1'b1;
		end else if (status_write && hwdata[BFIE_ST_DROPPED]) begin
			cmd_dropped <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_op <= BFIE_OP_NOP;
		end else if (cmd_go) begin
			last_op <= cmd_op;
		end
	end

	// Read data is captured at the address phase, so a write in the
	// preceding data phase is not yet visible to a back-to-back read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= BFIE_UNMAPPED_READ;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			if (haddr[7:0] == BFIE_STATUS_ADDR) begin
				hrdata <= {24'h00_0000, last_op, 2'b00, cmd_dropped, busy};
			end else if (haddr[7:0] == BFIE_FLAGS_ADDR) begin
				hrdata <= {24'h00_0000, flag_register};
			end else if (!rd_widx[IDX_W]) begin
				hrdata <= {24'h00_0000, work_reg[rd_widx[IDX_W-1:0]]};
			end else if (!rd_iidx[IDX_W]) begin
				hrdata <= {24'h00_0000, io_reg[rd_iidx[IDX_W-1:0]]};
			end else begin
				hrdata <= BFIE_UNMAPPED_READ;
			end
		end
	end

endmodule

//--- logic/bfie_pkg.sv
/*
 * Package of the bit and flag instruction executer: register map, command
 * layout, opcodes, flag positions and cycle counts.
 * Assumes a single 200 MHz core clock and an AHB-Lite register bus.
 */
package bfie_pkg;

	// Register byte addresses
	localparam logic [7:0] BFIE_CMD_ADDR = 8'h00;
	localparam logic [7:0] BFIE_STATUS_ADDR = 8'h04;
	localparam logic [7:0] BFIE_FLAGS_ADDR = 8'h08;
	localparam logic [7:0] BFIE_WREG_BASE = 8'h10;
	localparam logic [7:0] BFIE_IOREG_BASE = 8'h30;
	localparam int BFIE_NUM_REGS = 8;

	// Command word fields
	localparam int BFIE_CMD_OP_LSB = 0;
	localparam int BFIE_CMD_REG_LSB = 4;
	localparam int BFIE_CMD_BIT_LSB = 8;

	// Status word fields
	localparam int BFIE_ST_BUSY = 0;
	localparam int BFIE_ST_DROPPED = 1;
	localparam int BFIE_ST_LASTOP_LSB = 4;

	// Flag register bit positions
	localparam int BFIE_F_CARRY = 0;
	localparam int BFIE_F_ZERO = 1;
	localparam int BFIE_F_NEG = 2;
	localparam int BFIE_F_OVF = 3;
	localparam int BFIE_F_SIGN = 4;
	localparam int BFIE_F_HALF = 5;
	localparam int BFIE_F_COPY = 6;
	localparam int BFIE_F_IRQ = 7;

	// Reset values
	localparam logic [7:0] BFIE_FLAGS_RESET = 8'h00;
	localparam logic [7:0] BFIE_REG_RESET = 8'h00;
	localparam logic [31:0] BFIE_UNMAPPED_READ = 32'h0000_0000;

	// Cycle counts
	localparam int BFIE_IO_BIT_CYCLES = 2;
	localparam int BFIE_SHIFT_CYCLES = 1;

	// Opcodes
	localparam logic [3:0] BFIE_OP_NOP = 4'h0;
	localparam logic [3:0] BFIE_OP_IO_BIT_ASSERT = 4'h1;
	localparam logic [3:0] BFIE_OP_IO_BIT_NEGATE = 4'h2;
	localparam logic [3:0] BFIE_OP_LEFT_LOGICAL_SHIFT = 4'h3;
	localparam logic [3:0] BFIE_OP_RIGHT_LOGICAL_SHIFT = 4'h4;
	localparam logic [3:0] BFIE_OP_LEFT_CARRY_ROTATE = 4'h5;
	localparam logic [3:0] BFIE_OP_RIGHT_CARRY_ROTATE = 4'h6;
	localparam logic [3:0] BFIE_OP_RIGHT_ARITH_SHIFT = 4'h7;
	localparam logic [3:0] BFIE_OP_FLAG_FROM_REG_BIT = 4'h8;
	localparam logic [3:0] BFIE_OP_REG_BIT_FROM_FLAG = 4'h9;
	localparam logic [3:0] BFIE_OP_OVERRUN_RAISE = 4'hA;
	localparam logic [3:0] BFIE_OP_OVERRUN_DROP = 4'hB;
	localparam logic [3:0] BFIE_OP_NIBBLE_RAISE = 4'hC;
	localparam logic [3:0] BFIE_OP_NIBBLE_DROP = 4'hD;
	localparam logic [3:0] BFIE_OP_SIGN_RAISE = 4'hE;
	localparam logic [3:0] BFIE_OP_SIGN_DROP = 4'hF;

	typedef enum logic [0:0] {
		BFIE_IDLE,
		BFIE_IO_WRITE
	} bfie_state_e;

endpackage

//--- logic/bfie_shift_unit.sv
/*
 * Combinational shift and rotate unit with its Z, C, N, V results.
 * Assumes the caller only looks at the outputs for shift opcodes.
 */
`timescale 1ns/1ps
module bfie_shift_unit (
	// Operation
	input wire logic [3:0] op,
	input wire logic [7:0] operand,
	input wire logic carry_in,
	// Results
	output logic [7:0] result,
	output logic carry_out,
	output logic zero_out,
	output logic neg_out,
	output logic ovf_out
);
	import bfie_pkg::*;

	always_comb begin
		result = operand;
		carry_out = carry_in;
		case (op)
			BFIE_OP_LEFT_LOGICAL_SHIFT: begin
				result = {operand[6:0], 1'b0};
				carry_out = operand[7];
			end
			BFIE_OP_RIGHT_LOGICAL_SHIFT: begin
				result = {1'b0, operand[7:1]};
				carry_out = operand[0];
			end
			BFIE_OP_LEFT_CARRY_ROTATE: begin
				result = {operand[6:0], carry_in};
				carry_out = operand[7];
			end
			BFIE_OP_RIGHT_CARRY_ROTATE: begin
				result = {carry_in, operand[7:1]};
				carry_out = operand[0];
			end
			BFIE_OP_RIGHT_ARITH_SHIFT: begin
				result = {operand[7], operand[7:1]};
				carry_out = operand[0];
			end
			default: begin
				result = operand;
				carry_out = carry_in;
			end
		endcase
		zero_out = (result == 8'h00);
		neg_out = result[7];
		// Overflow as sign change seen against the carried-out bit
		ovf_out = result[7] ^ carry_out;
	end

endmodule

//--- verif/bfie_exec_checker.sv
/* Checker of the bit and flag executer: flag effects and timing of commands.
 * Assumes hready is tied to hreadyout and a single bus master. */
`timescale 1ns/1ps
module bfie_exec_checker
	import bfie_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Core view
	input wire logic [7:0] flag_register,
	input wire logic busy
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A command lands at its data-phase edge unless an I/O command still runs
	sequence cmd_s(logic [3:0] lo, logic [3:0] hi);
		hsel && hready && htrans[1] && hwrite && haddr[7:0] == BFIE_CMD_ADDR
		##1 !busy && hwdata[3:0] >= lo && hwdata[3:0] <= hi;
	endsequence
	property flag_p(logic [3:0] op, int pos, logic v);
		cmd_s(op, op) |=> flag_register[pos] == v &&
			((flag_register ^ $past(flag_register)) & ~(8'h01 << pos)) == 8'h00;
	endproperty
	a_io_bit_timing:
		assert property (cmd_s(4'h1, 4'h2) |=> busy && $stable(flag_register) ##1
			!busy && $stable(flag_register)) else $error("io bit command timing wrong");
	a_shift_flags:
		assert property (cmd_s(4'h3, 4'h7) |=> !busy && flag_register[BFIE_F_OVF] ==
			(flag_register[BFIE_F_NEG] ^ flag_register[BFIE_F_CARRY]) &&
			flag_register[7:4] == $past(flag_register[7:4])) else $error("shift flags wrong");
	a_copy_flag_only:
		assert property (cmd_s(4'h8, 4'h8) |=> ((flag_register ^ $past(flag_register))
			& 8'hBF) == 8'h00) else $error("bit copy touched other flags");
	a_bit_load_flags:
		assert property (cmd_s(4'h9, 4'h9) |=> $stable(flag_register) && !busy)
			else $error("bit load changed flags");
	a_overrun_raise:
		assert property (flag_p(4'hA, BFIE_F_OVF, 1'h1)) else $error("overrun raise wrong");
	a_overrun_drop:
		assert property (flag_p(4'hB, BFIE_F_OVF, 1'h0)) else $error("overrun drop wrong");
	a_nibble_raise:
		assert property (flag_p(4'hC, BFIE_F_HALF, 1'h1)) else $error("nibble raise wrong");
	a_nibble_drop:
		assert property (flag_p(4'hD, BFIE_F_HALF, 1'h0)) else $error("nibble drop wrong");
	a_sign_raise:
		assert property (flag_p(4'hE, BFIE_F_SIGN, 1'h1)) else $error("sign raise wrong");
	a_sign_drop:
		assert property (flag_p(4'hF, BFIE_F_SIGN, 1'h0)) else $error("sign drop wrong");
endmodule

bind bfie_exec bfie_exec_checker bfie_exec_checker_inst (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .flag_register(flag_register), .busy(busy));

//--- verif/tb.sv
/* Self-checking bench of the bit and flag executer against an integer model.
 * Assumes the zero-wait AHB-Lite slave and the register map of the package. */
`timescale 1ns/1ps
module tb;
	import bfie_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] flag_register, mf;
	int fail_count, num_checks;
	int wr [8];
	int io [8];

	bfie_exec bfie_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.flag_register(flag_register), .busy(busy));

	initial begin
		hclk = 1'h0;
		forever #2.5 hclk = ~hclk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Bounded so that a stuck slave still reaches the verdict
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1) begin
			n++;
			if (n > 50) begin
				fail_count++;
				$display("unexpected at %0t: bus hang", $time);
				conclude();
			end
			@(posedge hclk);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'h1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask

	task automatic cmp2(input logic [31:0] q, input int ev, input string what);
		logic [31:0] f;
		check(q, 32'(ev), what);
		bus(BFIE_FLAGS_ADDR, 1'h0, 32'h0000_0000, f);
		check(f, {24'h00_0000, mf}, what);
		// The flag port must agree with the bus view of the same register
		check({24'h00_0000, flag_register}, {24'h00_0000, mf}, what);
	endtask

	initial begin
		logic [31:0] q;
		int op, r, b, c, x, y, pos;
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		void'($urandom(32'h09ef_093f));
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		// Stray write to an unmapped word; later results show it disturbed nothing
		bus(8'hFC, 1'h1, 32'hFFFF_FFFF, q);
		for (int i = 0; i < 60; i++) begin
			op = i % 16;
			r = $urandom_range(7);
			b = $urandom_range(7);
			wr[r] = $urandom_range(255);
			io[r] = $urandom_range(255);
			mf = 8'($urandom_range(255));
			bus(BFIE_WREG_BASE + 8'(4 * r), 1'h1, 32'(wr[r]), q);
			bus(BFIE_IOREG_BASE + 8'(4 * r), 1'h1, 32'(io[r]), q);
			bus(BFIE_FLAGS_ADDR, 1'h1, {24'h00_0000, mf}, q);
			bus(BFIE_CMD_ADDR, 1'h1, 32'(op | r << 4 | b << 8), q);
			x = wr[r];
			c = mf[BFIE_F_CARRY];
			case (op)
				0: y = x;
				1: io[r] = io[r] | 1 << b;
				2: io[r] = io[r] & ~(1 << b);
				3: y = x << 1 & 255;
				4: y = x >> 1;
				5: y = (x << 1 | c) & 255;
				6: y = x >> 1 | c << 7;
				7: y = x >> 1 | x & 128;
				8: mf[BFIE_F_COPY] = 1'(x >> b);
				9: wr[r] = mf[BFIE_F_COPY] ? x | 1 << b : x & ~(1 << b);
				default: begin
					pos = op < 12 ? BFIE_F_OVF : op < 14 ? BFIE_F_HALF : BFIE_F_SIGN;
					mf[pos] = op % 2 == 0;
				end
			endcase
			if (op >= 3 && op <= 7) begin
				c = (op == 3 || op == 5) ? x >> 7 : x & 1;
				wr[r] = y;
				mf[BFIE_F_CARRY] = c[0];
				mf[BFIE_F_ZERO] = y == 0;
				mf[BFIE_F_NEG] = y[7];
				mf[BFIE_F_OVF] = mf[BFIE_F_NEG] ^ mf[BFIE_F_CARRY];
			end
			// An I/O write-back lands one edge after the command's data phase
			repeat (2) @(posedge hclk);
			bus((op < 3 ? BFIE_IOREG_BASE : BFIE_WREG_BASE) + 8'(4 * r), 1'h0, 32'h0, q);
			if (op < 3) begin
				cmp2(q, io[r], "io bit");
			end else if (op < 8) begin
				cmp2(q, wr[r], "shift");
			end else if (op < 10) begin
				cmp2(q, wr[r], "bit copy");
			end else begin
				cmp2(q, wr[r], "flag force");
			end
			// Busy must be gone, nothing dropped, and the last opcode recorded
			bus(BFIE_STATUS_ADDR, 1'h0, 32'h0, q);
			check(q, 32'(op << BFIE_ST_LASTOP_LSB), "status");
		end
		$display("command sweep done");
		conclude();
	end
endmodule
